// ==== mit_pkg.sv ====
package mit_pkg;
  localparam int PC_W = 11;
  localparam int IW = 16;
  localparam int DW = 8;
  localparam int OPC_LSB = 11;
  localparam int IR_DEST_BIT = 10;
  localparam int IR_BIT_LSB = 8;
  localparam int STACK_DEPTH = 8;
  localparam logic [2:0] TBL_PAGE = 3'h7;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_ONE = 11'h001;
  localparam logic [PC_W-1:0] PC_TWO = 11'h002;
  localparam logic [DW-1:0] PROGRAM_COUNTER_LOW_BYTE_ADDR = 8'h06;
  localparam logic [DW-1:0] ACC_RESET = 8'h00;
  localparam logic [1:0] SYS_NOP = 2'h0;
  localparam logic [1:0] SYS_HALT = 2'h1;
  localparam logic [1:0] SYS_WDT = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_ACC = 2'h2;
  localparam logic [1:0] REG_TBLH = 2'h3;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WAKE = 1;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int STAT_Z = 0;
  localparam int STAT_C = 1;
  localparam int STAT_AC = 2;
  localparam int STAT_OV = 3;
  localparam int STAT_SC = 4;
  localparam int STAT_HALT = 5;

  typedef enum logic [4:0] {
    OP_SYS = 5'h00, OP_TRANSFER_TO_ACC = 5'h01,
    OP_TRANSFER_TO_MEM = 5'h02, OP_TRANSFER_IMM = 5'h03,
    OP_ADD = 5'h04, OP_ADD_CARRY = 5'h05, OP_SUB = 5'h06,
    OP_SUB_CARRY = 5'h07, OP_ADD_IMM = 5'h08, OP_SUB_IMM = 5'h09,
    OP_AND = 5'h0A, OP_OR = 5'h0B, OP_XOR = 5'h0C, OP_AND_IMM = 5'h0D,
    OP_OR_IMM = 5'h0E, OP_XOR_IMM = 5'h0F, OP_BITWISE_INVERT = 5'h10,
    OP_ADD_ONE = 5'h11, OP_SUBTRACT_ONE = 5'h12, OP_ROTATE_RIGHT = 5'h13,
    OP_ROTATE_LEFT = 5'h14, OP_ROTATE_RIGHT_VIA_CARRY = 5'h15,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h16, OP_BIT_FORCE_ONE = 5'h17,
    OP_BIT_FORCE_ZERO = 5'h18, OP_SKIP_ZERO = 5'h19,
    OP_SKIP_BIT_ZERO = 5'h1A, OP_SKIP_BIT_ONE = 5'h1B, OP_JUMP = 5'h1C,
    OP_CALL = 5'h1D, OP_SUBROUTINE_EXIT = 5'h1E, OP_TABLE_READ = 5'h1F
  } mit_op_t;

  typedef enum logic [4:0] {
    ST_T1 = 5'h01, ST_T2 = 5'h02, ST_T3 = 5'h04, ST_T4 = 5'h08,
    ST_HALT = 5'h10
  } mit_state_t;

  function automatic logic is_imm(mit_op_t op);
    return op inside {OP_TRANSFER_IMM, OP_ADD_IMM, OP_SUB_IMM, OP_AND_IMM,
                      OP_OR_IMM, OP_XOR_IMM};
  endfunction

  function automatic logic has_result(mit_op_t op);
    return !(op inside {OP_SYS, OP_SKIP_ZERO, OP_SKIP_BIT_ZERO,
                        OP_SKIP_BIT_ONE, OP_JUMP, OP_CALL,
                        OP_SUBROUTINE_EXIT, OP_TABLE_READ});
  endfunction

  function automatic logic to_mem(mit_op_t op, logic dest);
    return has_result(op) && !is_imm(op) && (op != OP_TRANSFER_TO_ACC) &&
           (dest || op inside {OP_TRANSFER_TO_MEM, OP_BIT_FORCE_ONE,
                               OP_BIT_FORCE_ZERO});
  endfunction
endpackage

// ==== mit_ret_mem.sv ====
module mit_ret_mem #(
  parameter int DEPTH = 8,
  parameter int W = 11,
  parameter int AW = 3
) (
  input logic mclk_i,
  input logic we_i,
  input logic [AW-1:0] waddr_i,
  input logic [W-1:0] wdata_i,
  input logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_q [DEPTH];

  // Return points, read data registered every cycle
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule // mit_ret_mem

// ==== mit_alu.sv ====
module mit_alu import mit_pkg::*; (
  input mit_op_t op_i,
  input logic [DW-1:0] a_i,
  input logic [DW-1:0] m_i,
  input logic cin_i,
  input logic [2:0] bsel_i,
  output logic [DW-1:0] res_o,
  output logic z_o,
  output logic c_o,
  output logic ac_o,
  output logic ov_o,
  output logic sc_o,
  output logic upd_arith_o,
  output logic upd_c_o,
  output logic upd_z_o
);
  logic sub_w;
  logic cin_w;
  logic [DW-1:0] opb;
  logic [DW:0] sum9;
  logic [4:0] nib;

  always_comb begin
    sub_w = op_i inside {OP_SUB, OP_SUB_CARRY, OP_SUB_IMM};
    case (op_i)
      OP_ADD_CARRY, OP_SUB_CARRY: cin_w = cin_i;
      OP_SUB, OP_SUB_IMM: cin_w = 1'b1;
      default: cin_w = 1'b0;
    endcase
    opb = sub_w ? ~m_i : m_i;
    // Nine-bit sum keeps carry out and borrow of the 8-bit datapath
    sum9 = {1'b0, a_i} + {1'b0, opb} + {8'h00, cin_w};
    nib = {1'b0, a_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin_w};
    ac_o = nib[4];
    ov_o = (a_i[7] == opb[7]) && (sum9[7] != a_i[7]);
    sc_o = ov_o ^ sum9[7];
    res_o = m_i;
    c_o = cin_i;
    upd_arith_o = 1'b0;
    upd_c_o = 1'b0;
    upd_z_o = 1'b0;
    case (op_i)
      OP_ADD, OP_ADD_CARRY, OP_ADD_IMM, OP_SUB, OP_SUB_CARRY,
      OP_SUB_IMM: begin
        res_o = sum9[DW-1:0];
        c_o = sum9[DW];
        upd_arith_o = 1'b1;
      end
      OP_TRANSFER_TO_MEM: res_o = a_i;
      OP_AND, OP_AND_IMM: begin
        res_o = a_i & m_i;
        upd_z_o = 1'b1;
      end
      OP_OR, OP_OR_IMM: begin
        res_o = a_i | m_i;
        upd_z_o = 1'b1;
      end
      OP_XOR, OP_XOR_IMM: begin
        res_o = a_i ^ m_i;
        upd_z_o = 1'b1;
      end
      OP_BITWISE_INVERT: begin
        res_o = ~m_i;
        upd_z_o = 1'b1;
      end
      OP_ADD_ONE: begin
        res_o = m_i + 8'h01;
        upd_z_o = 1'b1;
      end
      OP_SUBTRACT_ONE: begin
        res_o = m_i - 8'h01;
        upd_z_o = 1'b1;
      end
      OP_ROTATE_RIGHT: res_o = {m_i[0], m_i[DW-1:1]};
      OP_ROTATE_LEFT: res_o = {m_i[DW-2:0], m_i[DW-1]};
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        res_o = {cin_i, m_i[DW-1:1]};
        c_o = m_i[0];
        upd_c_o = 1'b1;
      end
      OP_ROTATE_LEFT_VIA_CARRY: begin
        res_o = {m_i[DW-2:0], cin_i};
        c_o = m_i[DW-1];
        upd_c_o = 1'b1;
      end
      OP_BIT_FORCE_ONE: res_o = m_i | (8'h01 << bsel_i);
      OP_BIT_FORCE_ZERO: res_o = m_i & ~(8'h01 << bsel_i);
      default: res_o = m_i;
    endcase
    z_o = (res_o == 8'h00);
  end
endmodule // mit_alu

// ==== mit_core.sv ====
// Overview of operation
// - Ordinary instructions take one cycle; jump, call, returns, table read take two.
// - Every instruction cycle lasts exactly four system clock periods while the run bit is set; a clear run bit holds T1.
// - Writing the program counter low byte jumps there, costing one extra cycle.
// - Skip not taken costs one cycle; a taken skip costs one more.
// - Conditional branches test a memory byte or bit, then execute or skip next.
// - Call saves the return point; return resumes after the call; jump saves nothing.
// - Add and subtract report carry above 255 and borrow below zero.
// - Increment and decrement change the destination by exactly one.
// - Logical and invert operations set zero flag when the result is zero.
// - Rotates shift one bit; the bit leaving one end enters the other.
// - Rotate via carry moves outgoing bit to carry and old carry inward.
// - Bit force one/zero changes one memory bit, keeping the others.
// - Transfers move register to accumulator, accumulator to register, or immediate in.
// - Table read fetches constant data from program memory to the data side.
// - A power-down instruction stops execution; another services the watchdog.
// - Add memory to accumulator takes one cycle, updates Z, C, AC, OV, SC.
//
// The register addresses and strobed register access were decided locally.
module mit_core import mit_pkg::*; #(
  parameter int STACK_DEPTH_P = STACK_DEPTH,
  parameter logic [2:0] TBL_PAGE_P = TBL_PAGE
) (
  input logic mclk_i,
  input logic sys_rst_i,
  output logic [PC_W-1:0] pm_addr_o,
  input logic [IW-1:0] pm_data_i,
  output logic [DW-1:0] dm_addr_o,
  output logic dm_re_o,
  output logic dm_we_o,
  output logic [DW-1:0] dm_wdata_o,
  input logic [DW-1:0] dm_rdata_i,
  output logic wdt_clear_o,
  output logic halted_o,
  input logic [1:0] reg_addr_i,
  input logic [DW-1:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  output logic [DW-1:0] reg_rdata_o
);
  localparam int SP_W = $clog2(STACK_DEPTH_P);

  mit_state_t st_q;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [IW-1:0] ir_q;
  logic [DW-1:0] acc_q, tblh_q;
  logic z_q, c_q, ac_q, ov_q, sc_q;
  logic dummy_q, tbl_pend_q, run_q;
  logic [SP_W-1:0] sp_q;
  logic [PC_W-1:0] stk_rdata_w;
  mit_op_t op_w;
  logic [DW-1:0] opnd_w, res_w, bit_mask_w;
  logic exec_w, mem_wr_w, acc_wr_w, pcl_w, skip_w, two_w, halt_w;
  logic alu_z, alu_c, alu_ac, alu_ov, alu_sc;
  logic upd_arith, upd_c, upd_z, add_cy_w;
  logic [PC_W-1:0] tgt_w, tbl_addr_w;
  logic [DW-1:0] stat_w;

  assign op_w = mit_op_t'(ir_q[IW-1:OPC_LSB]);
  assign exec_w = (st_q == ST_T4) && !dummy_q;
  assign tgt_w = ir_q[PC_W-1:0];
  assign tbl_addr_w = {TBL_PAGE_P, acc_q};
  assign bit_mask_w = 8'h01 << ir_q[IR_BIT_LSB +: 3];
  assign mem_wr_w = to_mem(op_w, ir_q[IR_DEST_BIT]);
  assign acc_wr_w = has_result(op_w) && !mem_wr_w;
  assign pcl_w = mem_wr_w &&
                 (ir_q[DW-1:0] == PROGRAM_COUNTER_LOW_BYTE_ADDR);
  assign halt_w = exec_w && (op_w == OP_SYS) && (ir_q[1:0] == SYS_HALT);
  assign add_cy_w = ({1'b0, acc_q} + {1'b0, opnd_w}) > 9'h0FF;

  // Operand select: immediate field, live program counter, or data memory
  always_comb begin
    if (is_imm(op_w)) begin
      opnd_w = ir_q[DW-1:0];
    end else if (ir_q[DW-1:0] == PROGRAM_COUNTER_LOW_BYTE_ADDR) begin
      opnd_w = pc_q[DW-1:0];
    end else begin
      opnd_w = dm_rdata_i;
    end
  end

  mit_alu u_alu (
    .op_i(op_w),
    .a_i(acc_q),
    .m_i(opnd_w),
    .cin_i(c_q),
    .bsel_i(ir_q[IR_BIT_LSB +: 3]),
    .res_o(res_w),
    .z_o(alu_z),
    .c_o(alu_c),
    .ac_o(alu_ac),
    .ov_o(alu_ov),
    .sc_o(alu_sc),
    .upd_arith_o(upd_arith),
    .upd_c_o(upd_c),
    .upd_z_o(upd_z)
  );

  // Next program counter and whether a second instruction cycle follows
  always_comb begin
    pc_d = pc_q + PC_ONE;
    two_w = 1'b0;
    case (op_w)
      OP_SKIP_ZERO: skip_w = (opnd_w == 8'h00);
      OP_SKIP_BIT_ZERO: skip_w = !(|(opnd_w & bit_mask_w));
      OP_SKIP_BIT_ONE: skip_w = |(opnd_w & bit_mask_w);
      default: skip_w = 1'b0;
    endcase
    case (op_w)
      OP_JUMP, OP_CALL: begin
        pc_d = tgt_w;
        two_w = 1'b1;
      end
      OP_SUBROUTINE_EXIT: begin
        pc_d = stk_rdata_w;
        two_w = 1'b1;
      end
      OP_TABLE_READ: two_w = 1'b1;
      default: begin
        if (skip_w) begin
          pc_d = pc_q + PC_TWO;
          two_w = 1'b1;
        end
      end
    endcase
    if (pcl_w) begin
      pc_d = {pc_q[PC_W-1:DW], res_w};
      two_w = 1'b1;
    end
  end

  // Four-phase instruction cycle sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_T1;
    end else begin
      unique case (st_q)
        ST_T1: if (run_q) st_q <= ST_T2;
        ST_T2: st_q <= ST_T3;
        ST_T3: st_q <= ST_T4;
        ST_T4: st_q <= halt_w ? ST_HALT : ST_T1;
        ST_HALT: if (!halted_o) st_q <= ST_T1;
        default: st_q <= ST_T1;
      endcase
    end
  end

  // Program counter, fetch address and second-cycle bookkeeping
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pc_q <= PC_RESET;
      pm_addr_o <= PC_RESET;
      dummy_q <= 1'b0;
      tbl_pend_q <= 1'b0;
    end else if (exec_w) begin
      pc_q <= pc_d;
      dummy_q <= two_w;
      tbl_pend_q <= (op_w == OP_TABLE_READ);
      pm_addr_o <= (op_w == OP_TABLE_READ) ? tbl_addr_w : pc_d;
    end else if (st_q == ST_T4) begin
      dummy_q <= 1'b0;
      tbl_pend_q <= 1'b0;
      pm_addr_o <= pc_q;
    end
  end

  // Instruction latch and table data capture
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ir_q <= 16'h0000;
      tblh_q <= 8'h00;
    end else if (st_q == ST_T2) begin
      if (!dummy_q) begin
        ir_q <= pm_data_i;
      end
      if (tbl_pend_q) begin
        tblh_q <= pm_data_i[IW-1:DW];
      end
    end
  end

  // Data memory port
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dm_addr_o <= 8'h00;
      dm_re_o <= 1'b0;
      dm_we_o <= 1'b0;
      dm_wdata_o <= 8'h00;
    end else begin
      dm_re_o <= (st_q == ST_T2) && !dummy_q;
      dm_we_o <= 1'b0;
      if ((st_q == ST_T2) && !dummy_q) begin
        dm_addr_o <= pm_data_i[DW-1:0];
      end
      if ((st_q == ST_T2) && tbl_pend_q) begin
        dm_we_o <= 1'b1;
        dm_wdata_o <= pm_data_i[DW-1:0];
      end
      if (exec_w && mem_wr_w && !pcl_w) begin
        dm_we_o <= 1'b1;
        dm_wdata_o <= res_w;
      end
    end
  end

  // Accumulator and status flags
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      acc_q <= ACC_RESET;
      {z_q, c_q, ac_q, ov_q, sc_q} <= 5'h00;
    end else if (exec_w) begin
      if (acc_wr_w) begin
        acc_q <= res_w;
      end
      if (upd_arith) begin
        {z_q, c_q, ac_q, ov_q, sc_q} <=
          {alu_z, alu_c, alu_ac, alu_ov, alu_sc};
      end
      if (upd_z) begin
        z_q <= alu_z;
      end
      if (upd_c) begin
        c_q <= alu_c;
      end
    end
  end

  // Return stack pointer: only a call pushes, only a return pops
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sp_q <= '0;
    end else if (exec_w && op_w == OP_CALL) begin
      sp_q <= sp_q + 1'b1;
    end else if (exec_w && op_w == OP_SUBROUTINE_EXIT) begin
      sp_q <= sp_q - 1'b1;
    end
  end

  mit_ret_mem #(
    .DEPTH(STACK_DEPTH_P),
    .W(PC_W),
    .AW(SP_W)
  ) u_stack (
    .mclk_i(mclk_i),
    .we_i(exec_w && op_w == OP_CALL),
    .waddr_i(sp_q),
    .wdata_i(pc_q + PC_ONE),
    .raddr_i(sp_q - 1'b1),
    .rdata_o(stk_rdata_w)
  );

  // Power-down and watchdog service; a halt beats a simultaneous wake
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      halted_o <= 1'b0;
      wdt_clear_o <= 1'b0;
    end else begin
      wdt_clear_o <= exec_w && (op_w == OP_SYS) &&
                     (ir_q[1:0] == SYS_WDT);
      if (halt_w) begin
        halted_o <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == REG_CTRL &&
                   reg_wdata_i[CTRL_WAKE]) begin
        halted_o <= 1'b0;
      end
    end
  end

  always_comb begin
    stat_w = 8'h00;
    stat_w[STAT_Z] = z_q;
    stat_w[STAT_C] = c_q;
    stat_w[STAT_AC] = ac_q;
    stat_w[STAT_OV] = ov_q;
    stat_w[STAT_SC] = sc_q;
    stat_w[STAT_HALT] = halted_o;
  end

  // Register port: read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_q <= CTRL_RUN_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        run_q <= reg_wdata_i[CTRL_RUN];
      end
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          REG_CTRL: reg_rdata_o <= {7'h00, run_q};
          REG_STAT: reg_rdata_o <= stat_w;
          REG_ACC: reg_rdata_o <= acc_q;
          REG_TBLH: reg_rdata_o <= tblh_q;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_phase_four_clocks: assert property (
    st_q == ST_T2 |-> ##1 st_q == ST_T3 ##1 st_q == ST_T4
      ##1 (st_q == ST_T1 || st_q == ST_HALT))
    else $error("instruction cycle not four clocks");
  a_plain_one_cycle: assert property (
    exec_w && has_result(op_w) && !pcl_w |=> !dummy_q)
    else $error("ordinary instruction took an extra cycle");
  a_branch_two_cycle: assert property (
    exec_w && op_w inside {OP_JUMP, OP_CALL, OP_SUBROUTINE_EXIT,
                           OP_TABLE_READ} |=> dummy_q)
    else $error("branch did not take a second cycle");
  a_dummy_single: assert property (
    st_q == ST_T4 && dummy_q |=> !dummy_q)
    else $error("second cycle repeated");
  a_pcl_jump: assert property (
    exec_w && pcl_w |=> dummy_q && pc_q[DW-1:0] == $past(res_w))
    else $error("counter low write did not jump");
  a_skip_taken: assert property (
    exec_w && skip_w |=> dummy_q && pc_q == $past(pc_q) + PC_TWO)
    else $error("taken skip wrong");
  a_skip_not_taken: assert property (
    exec_w && !skip_w && op_w inside {OP_SKIP_ZERO, OP_SKIP_BIT_ZERO,
      OP_SKIP_BIT_ONE} |=> !dummy_q && pc_q == $past(pc_q) + PC_ONE)
    else $error("untaken skip wrong");
  a_call_target: assert property (
    exec_w && op_w == OP_CALL |=> pc_q == $past(tgt_w) &&
      sp_q == $past(sp_q) + 1'b1)
    else $error("call did not push and jump");
  a_jump_no_push: assert property (
    exec_w && op_w == OP_JUMP |=> $stable(sp_q))
    else $error("jump changed the stack");
  a_return_point: assert property (
    exec_w && op_w == OP_SUBROUTINE_EXIT |=> pc_q == $past(stk_rdata_w))
    else $error("return went to wrong address");
  a_add_carry: assert property (
    exec_w && op_w == OP_ADD |=> c_q == $past(add_cy_w))
    else $error("add carry wrong");
  a_inc_by_one: assert property (
    exec_w && op_w == OP_ADD_ONE && ir_q[IR_DEST_BIT] && !pcl_w
      |=> dm_we_o && dm_wdata_o == $past(opnd_w) + 8'h01)
    else $error("increment not by one");
  a_logic_zero: assert property (
    exec_w && op_w == OP_AND && (acc_q & opnd_w) == 8'h00 |=> z_q)
    else $error("zero flag not set");
  a_rotate_carry_in: assert property (
    exec_w && op_w == OP_ROTATE_RIGHT_VIA_CARRY && !ir_q[IR_DEST_BIT]
      |=> acc_q[DW-1] == $past(c_q))
    else $error("old carry not rotated in");
  a_bit_clear: assert property (
    exec_w && op_w == OP_BIT_FORCE_ZERO && !pcl_w |=> dm_we_o &&
      dm_wdata_o == ($past(opnd_w) & ~$past(bit_mask_w)))
    else $error("bit clear wrong");
  a_table_fetch: assert property (
    exec_w && op_w == OP_TABLE_READ |=> pm_addr_o == $past(tbl_addr_w))
    else $error("table address wrong");
  a_halt_stops: assert property (
    halt_w |=> st_q == ST_HALT && halted_o)
    else $error("halt did not stop");

  c_call: cover property (exec_w && op_w == OP_CALL);
  c_skip: cover property (exec_w && skip_w);
  c_table: cover property (st_q == ST_T2 && tbl_pend_q);
  c_halt: cover property (halt_w);
endmodule // mit_core

// ==== mit_core_test.sv ====
module mit_core_test import mit_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [IW-1:0] pm_data_i = 16'h0000;
  logic [DW-1:0] dm_rdata_i = 8'h00;
  logic [1:0] reg_addr_i = 2'h0;
  logic [DW-1:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [PC_W-1:0] pm_addr_o;
  logic [DW-1:0] dm_addr_o;
  logic [DW-1:0] dm_wdata_o;
  logic [DW-1:0] reg_rdata_o;
  logic dm_re_o;
  logic dm_we_o;
  logic wdt_clear_o;
  logic halted_o;
  logic [IW-1:0] prog [0:2047];
  logic [DW-1:0] dmem [0:255];
  int fails = 0;
  int samples_checked = 0;
  int wdt_n = 0;
  int base_cyc = 0;
  int pc_w = 0;
  int n = 0;
  mit_op_t lo [4] = '{OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM, OP_BITWISE_INVERT};
  logic [DW-1:0] lv [4] = '{8'h5A, 8'h00, 8'h5A, 8'hFF};
  logic [DW-1:0] lx [4] = '{8'hA5, 8'h00, 8'h5A, 8'h16};

  mit_core i_mit_core (
    .mclk_i,
    .sys_rst_i,
    .pm_addr_o,
    .pm_data_i,
    .dm_addr_o,
    .dm_re_o,
    .dm_we_o,
    .dm_wdata_o,
    .dm_rdata_i,
    .wdt_clear_o,
    .halted_o,
    .reg_addr_i,
    .reg_wdata_i,
    .reg_wr_i,
    .reg_rd_i,
    .reg_rdata_o
  );

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // Program and data memory; idle read data toggles every cycle
  always @(posedge mclk_i) begin
    pm_data_i <= prog[pm_addr_o];
    if (dm_re_o === 1'b1) begin
      dm_rdata_i <= dmem[dm_addr_o];
    end else begin
      dm_rdata_i <= ~dm_rdata_i;
    end
    if (dm_we_o === 1'b1) begin
      dmem[dm_addr_o] <= dm_wdata_o;
    end
    if (wdt_clear_o === 1'b1) begin
      wdt_n <= wdt_n + 1;
    end
  end

  task automatic test_done();
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      fails++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask

  task automatic put(input mit_op_t op, input logic [10:0] arg);
    prog[pc_w] = {op, arg};
    pc_w++;
  endtask

  task automatic halt_here();
    put(OP_SYS, 11'h001);
  endtask

  // Fill all of program memory with power-down words
  task automatic clear_prog();
    for (int i = 0; i < 2048; i++) begin
      prog[i] = {OP_SYS, 11'h001};
    end
    pc_w = 0;
  endtask

  task automatic mem_init();
    dmem[8'h10] = 8'hF0;
    dmem[8'h11] = 8'h20;
    dmem[8'h12] = 8'h0F;
    dmem[8'h13] = 8'h81;
    dmem[8'h14] = 8'h00;
    dmem[8'h15] = 8'h00;
    dmem[8'h16] = 8'hFF;
    dmem[8'h17] = 8'h81;
    dmem[8'h18] = 8'h81;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic chk_reg(input logic [1:0] a, input logic [DW-1:0] m,
                         input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    chk_byte(d & m, exp);
  endtask

  // Bounded wait for power-down; counts clocks taken
  task automatic wait_halt(output int c);
    c = 0;
    while (halted_o !== 1'b1) begin
      @(posedge mclk_i);
      #1;
      c++;
      if (c > 2000) begin
        fails++;
        $display("unexpected at %0t: core never powered down", $time);
        test_done();
      end
    end
  endtask

  // Reset, run to power-down, compare against baseline plus k cycles
  task automatic run(input int k);
    int c;
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    wdt_n <= 0;
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    wait_halt(c);
    if (k < 0) begin
      base_cyc = c;
    end else begin
      chk_count(c, base_cyc + 4 * k);
    end
  endtask

  initial begin
    clear_prog();
    halt_here();
    mem_init();
    run(-1);
    chk_reg(REG_CTRL, 8'h01, 8'h01);
    chk_reg(REG_STAT, 8'h20, 8'h20);
    clear_prog();
    put(OP_TRANSFER_TO_ACC, {3'h0, 8'h10});
    put(OP_ADD, {3'h0, 8'h11});
    halt_here();
    mem_init();
    run(2);
    chk_reg(REG_ACC, 8'hFF, 8'h10);
    chk_reg(REG_STAT, 8'h1F, 8'h02);
    clear_prog();
    put(OP_TRANSFER_IMM, {3'h0, 8'h05});
    put(OP_SUB_IMM, {3'h0, 8'h06});
    halt_here();
    run(2);
    chk_reg(REG_ACC, 8'hFF, 8'hFF);
    chk_reg(REG_STAT, 8'h03, 8'h00);
    for (int i = 0; i < 4; i++) begin
      clear_prog();
      put(OP_TRANSFER_IMM, {3'h0, lv[i]});
      put(lo[i], {3'h0, lx[i]});
      halt_here();
      mem_init();
      run(2);
      chk_reg(REG_ACC, 8'hFF, 8'h00);
      chk_reg(REG_STAT, 8'h01, 8'h01);
    end
    clear_prog();
    put(OP_ADD_ONE, {3'h4, 8'h12});
    put(OP_SUBTRACT_ONE, {3'h0, 8'h13});
    put(OP_ROTATE_LEFT_VIA_CARRY, {3'h4, 8'h13});
    put(OP_ROTATE_RIGHT_VIA_CARRY, {3'h0, 8'h12});
    put(OP_ROTATE_RIGHT, {3'h4, 8'h17});
    put(OP_ROTATE_LEFT, {3'h4, 8'h18});
    halt_here();
    mem_init();
    run(6);
    chk_byte(dmem[8'h12], 8'h10);
    chk_byte(dmem[8'h13], 8'h02);
    chk_reg(REG_ACC, 8'hFF, 8'h88);
    chk_reg(REG_STAT, 8'h02, 8'h00);
    chk_byte(dmem[8'h17], 8'hC0);
    chk_byte(dmem[8'h18], 8'h03);
    clear_prog();
    put(OP_TRANSFER_TO_ACC, {3'h0, 8'h12});
    put(OP_AND, {3'h0, 8'h10});
    put(OP_TRANSFER_TO_ACC, {3'h0, 8'h16});
    put(OP_ADD, {3'h0, 8'h13});
    put(OP_ADD_CARRY, {3'h0, 8'h11});
    put(OP_SUB, {3'h0, 8'h11});
    put(OP_SUB_CARRY, {3'h0, 8'h11});
    put(OP_XOR, {3'h0, 8'h12});
    put(OP_OR, {3'h4, 8'h13});
    put(OP_TRANSFER_TO_MEM, {3'h0, 8'h14});
    halt_here();
    mem_init();
    run(10);
    chk_reg(REG_ACC, 8'hFF, 8'h6E);
    chk_reg(REG_STAT, 8'h03, 8'h02);
    chk_byte(dmem[8'h13], 8'hEF);
    chk_byte(dmem[8'h14], 8'h6E);
    clear_prog();
    put(OP_BIT_FORCE_ONE, {3'h3, 8'h11});
    put(OP_BIT_FORCE_ZERO, {3'h5, 8'h10});
    put(OP_SKIP_BIT_ZERO, {3'h5, 8'h10});
    put(OP_TRANSFER_IMM, {3'h0, 8'h55});
    put(OP_TRANSFER_IMM, {3'h0, 8'h33});
    put(OP_SKIP_BIT_ONE, {3'h0, 8'h10});
    put(OP_ADD_IMM, {3'h0, 8'h01});
    put(OP_SKIP_ZERO, {3'h0, 8'h14});
    put(OP_ADD_IMM, {3'h0, 8'h40});
    halt_here();
    mem_init();
    run(9);
    chk_byte(dmem[8'h11], 8'h28);
    chk_byte(dmem[8'h10], 8'hD0);
    chk_reg(REG_ACC, 8'hFF, 8'h34);
    clear_prog();
    put(OP_JUMP, 11'h004);
    put(OP_TRANSFER_IMM, {3'h0, 8'hEE});
    pc_w = 4;
    put(OP_CALL, 11'h008);
    put(OP_ADD_IMM, {3'h0, 8'h01});
    put(OP_TRANSFER_TO_MEM, {3'h0, PROGRAM_COUNTER_LOW_BYTE_ADDR});
    put(OP_TRANSFER_IMM, {3'h0, 8'hEE});
    put(OP_TRANSFER_IMM, {3'h0, 8'h0A});
    put(OP_SUBROUTINE_EXIT, 11'h000);
    run(10);
    chk_reg(REG_ACC, 8'hFF, 8'h0B);
    clear_prog();
    put(OP_TRANSFER_IMM, {3'h0, 8'h05});
    put(OP_TABLE_READ, {3'h0, 8'h15});
    put(OP_SYS, 11'h002);
    put(OP_SYS, 11'h000);
    halt_here();
    put(OP_TRANSFER_IMM, {3'h0, 8'h77});
    halt_here();
    prog[{TBL_PAGE, 8'h05}] = 16'hA5C3;
    mem_init();
    run(5);
    chk_byte(dmem[8'h15], 8'hC3);
    chk_reg(REG_TBLH, 8'hFF, 8'hA5);
    chk_count(wdt_n, 1);
    reg_write(REG_CTRL, 8'h03);
    @(posedge mclk_i);
    #1;
    chk_byte({7'h00, halted_o}, 8'h00);
    wait_halt(n);
    chk_reg(REG_ACC, 8'hFF, 8'h77);
    test_done();
  end
endmodule // mit_core_test
